// ### design/rsm_consts.svh
// How it works
// (R1) entering reset halts the core, reinitialises registers, fixes ports, stops interrupts and timers
// (R2) reset never clears data memory; only the stack pointer returns to default
// (R3) reset loads port latches with all ones, open drain, weak pull-ups stay enabled
// (R4) power-on and supply-monitor resets drive the reset pin low throughout the reset
// (R5) leaving reset clears the program counter and selects the internal oscillator
// (R6) after any reset the watchdog is enabled and ticks at system clock over twelve
// (R7) power-up holds reset with pin low until supply is good, then waits the delay
// (R8) power-on exit sets the power-on flag; every other reset clears it
// (R9) power-on forces the supply monitor on; other resets keep its setting
// (R10) software writing one to the pin reset flag bit forces a power-on reset
// (R11) supply below threshold pulls the pin low and holds reset until it recovers
// (R12) selecting an unready supply monitor as a reset source causes a system reset
// (R13) control bit seven switches the monitor; resets need it also selected as source
// (R14) release delay counts from a stable good supply, release synchronous to the clock
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define RSM_SUPPLY_CTRL_ADDR 8'hff
`define RSM_CAUSE_ADDR 8'hef
`define RSM_MON_EN_BIT 7
`define RSM_SUPPLY_STAT_BIT 6
`define RSM_PIN_FLAG_BIT 0
`define RSM_POR_FLAG_BIT 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RSM_PORT_RST 8'hff
`define RSM_PC_RST 16'h0000
`define RSM_PIN_GUARD 2'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RSM_CLK_PERIOD_NS 100
`define RSM_POR_DELAY_NS 300000
`define RSM_POR_DELAY_CYC (`RSM_POR_DELAY_NS / `RSM_CLK_PERIOD_NS)
`define RSM_WDT_DIV 12
`define RSM_MON_SETTLE_CYC 16'h01f4

`endif

// ### design/rsm_pkg.sv
package rsm_pkg;

  // reset sequencer phases, gray along pwr-dly-run
  typedef enum logic [2:0]
  {
    RSM_PWR = 3'h0,
    RSM_DLY = 3'h1,
    RSM_RUN = 3'h3,
    RSM_MON = 3'h2,
    RSM_SYS = 3'h7,
    RSM_PIN = 3'h6
  } rsm_phase_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rsm_sfr_req_type;

  typedef struct packed
  {
    rsm_phase_type phase;
    logic [11:0] dly_cnt;
    logic [15:0] mon_cnt;
    logic mon_en;
    logic mon_sel;
    logic por_flag;
    logic pin_flag;
    logic core_rst;
    logic pin_drive;
    logic [7:0] port_latch;
    logic port_od;
    logic pullup_en;
    logic clk_int;
    logic wdt_en;
    logic start_pulse;
    logic [7:0] rdata;
  } rsm_state_type;

  typedef struct packed
  {
    logic [3:0] cnt;
    logic tick;
  } rsm_div_state_type;

endpackage : rsm_pkg

// ### design/rsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    stage_nxt = {stage_r[0], d_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      stage_r <= {RST_VAL, RST_VAL};
    else
      stage_r <= stage_nxt;
  end

  assign q_o = stage_r[1];

endmodule : rsm_sync
`default_nettype wire

// ### design/rsm_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output logic tick_o
);

  localparam logic [3:0] LAST = 4'(`RSM_WDT_DIV - 1);

  rsm_pkg::rsm_div_state_type r;
  rsm_pkg::rsm_div_state_type nxt;

  // one-cycle tick every twelve clocks while enabled
  always_comb
  begin
    nxt = r;
    nxt.tick = 1'b0;
    if (!en_i)
      nxt.cnt = 4'h0;
    else if (r.cnt == LAST)
    begin
      nxt.cnt = 4'h0;
      nxt.tick = 1'b1; // R6
    end
    else
      nxt.cnt = r.cnt + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= nxt;
  end

  assign tick_o = r.tick;

endmodule : rsm_div
`default_nettype wire

// ### design/rsm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_top #(
  parameter logic [15:0] MON_SETTLE_CYC = `RSM_MON_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic rst_pin_n_i,
  input wire rsm_pkg::rsm_sfr_req_type sfr_i,
  input wire logic port_wr_i,
  input wire logic [7:0] port_data_i,
  input wire logic clk_ext_sel_i,
  input wire logic wdt_off_i,
  output logic [7:0] sfr_rdata_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic core_rst_o,
  output logic start_pulse_o,
  output logic [15:0] reset_vec_o,
  output logic [7:0] port_latch_o,
  output logic port_od_o,
  output logic pullup_en_o,
  output logic clk_int_o,
  output logic wdt_en_o,
  output logic wdt_tick_o
);

  localparam logic [11:0] POR_LAST = 12'(`RSM_POR_DELAY_CYC - 1);
  localparam int POR_LAST_INT = `RSM_POR_DELAY_CYC - 1;

  // ------------------------------------------------------------
  // pin and supply synchronisers
  // ------------------------------------------------------------
  logic [1:0] pins_s;
  logic supply_s;
  logic pin_s;

  rsm_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({rst_pin_n_i, supply_ok_i}),
    .q_o(pins_s)
  );

  assign supply_s = pins_s[0];
  assign pin_s = pins_s[1];

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  rsm_pkg::rsm_state_type r;
  rsm_pkg::rsm_state_type nxt;
  logic mon_stable;
  logic mon_trip;
  logic pin_trip;
  logic cause_wr;
  logic ctrl_wr;
  logic in_rst;

  // monitor counts as ready only after its settle time
  assign mon_stable = r.mon_en && (r.mon_cnt == MON_SETTLE_CYC);
  // a monitor reset needs enable, selection and a low supply
  assign mon_trip = r.mon_en && r.mon_sel && mon_stable && !supply_s; // R13
  // pin is ignored for a few cycles after release while our own drive drains
  assign pin_trip = !pin_s && (r.dly_cnt[1:0] == `RSM_PIN_GUARD);
  assign cause_wr = sfr_i.wr && (sfr_i.addr == `RSM_CAUSE_ADDR);
  assign ctrl_wr = sfr_i.wr && (sfr_i.addr == `RSM_SUPPLY_CTRL_ADDR);

  always_comb
  begin
    nxt = r;
    in_rst = 1'b1;
    nxt.start_pulse = 1'b0;
    // monitor settle counter, restarted whenever it is off
    if (!r.mon_en)
      nxt.mon_cnt = 16'h0000;
    else if (r.mon_cnt != MON_SETTLE_CYC)
      nxt.mon_cnt = r.mon_cnt + 16'h0001;
    unique case (r.phase)
      rsm_pkg::RSM_PWR:
      begin
        // hold until the synchronised supply reads good
        nxt.dly_cnt = 12'h000; // R7
        if (supply_s)
          nxt.phase = rsm_pkg::RSM_DLY; // R14
      end
      rsm_pkg::RSM_DLY:
      begin
        if (!supply_s)
          nxt.phase = rsm_pkg::RSM_PWR; // R7
        else if (r.dly_cnt == POR_LAST)
        begin
          nxt.phase = rsm_pkg::RSM_RUN; // R14
          nxt.dly_cnt = 12'h000;
          nxt.por_flag = 1'b1; // R8
        end
        else
          nxt.dly_cnt = r.dly_cnt + 12'h001; // R14
      end
      rsm_pkg::RSM_RUN:
      begin
        if (r.dly_cnt[1:0] != `RSM_PIN_GUARD)
          nxt.dly_cnt = r.dly_cnt + 12'h001;
        // priority: monitor, external pin, then software
        if (mon_trip)
          nxt.phase = rsm_pkg::RSM_MON; // R11
        else if (pin_trip)
          nxt.phase = rsm_pkg::RSM_PIN;
        else if (cause_wr && sfr_i.wdata[`RSM_PIN_FLAG_BIT])
          nxt.phase = rsm_pkg::RSM_PWR; // R10
        else if (cause_wr && sfr_i.wdata[`RSM_POR_FLAG_BIT])
        begin
          if (mon_stable)
            nxt.mon_sel = 1'b1; // R13
          else
            nxt.phase = rsm_pkg::RSM_SYS; // R12
        end
        else if (cause_wr)
          nxt.mon_sel = 1'b0;
        if (ctrl_wr && !mon_trip && !pin_trip)
          nxt.mon_en = sfr_i.wdata[`RSM_MON_EN_BIT]; // R13
      end
      rsm_pkg::RSM_MON:
      begin
        // released once the supply recovers
        if (supply_s)
          nxt.phase = rsm_pkg::RSM_RUN; // R11
      end
      rsm_pkg::RSM_SYS:
      begin
        nxt.phase = rsm_pkg::RSM_RUN;
      end
      rsm_pkg::RSM_PIN:
      begin
        if (pin_s)
        begin
          nxt.phase = rsm_pkg::RSM_RUN;
          nxt.pin_flag = 1'b1;
        end
      end
      default:
      begin
        nxt.phase = rsm_pkg::RSM_PWR;
      end
    endcase

    // exit from any reset other than power-on clears the power-on flag
    if (r.phase inside {rsm_pkg::RSM_MON, rsm_pkg::RSM_SYS, rsm_pkg::RSM_PIN} &&
        nxt.phase == rsm_pkg::RSM_RUN)
    begin
      nxt.por_flag = 1'b0; // R8
      nxt.dly_cnt = 12'h000;
      if (r.phase != rsm_pkg::RSM_PIN)
        nxt.pin_flag = 1'b0;
    end

    in_rst = (nxt.phase != rsm_pkg::RSM_RUN);
    // power-on forces the monitor on, other resets keep it
    if (nxt.phase == rsm_pkg::RSM_PWR)
      nxt.mon_en = 1'b1; // R9
    if (in_rst)
      nxt.mon_sel = 1'b0; // R1
    // reset outputs; data memory has no clear path from here
    nxt.core_rst = in_rst; // R1 R2
    nxt.pin_drive = nxt.phase inside {rsm_pkg::RSM_PWR, rsm_pkg::RSM_DLY, rsm_pkg::RSM_MON}; // R4
    nxt.pullup_en = 1'b1; // R3
    // core requests are ignored on the exit cycle too, so the core starts from defaults
    if (in_rst || r.core_rst)
    begin
      nxt.port_latch = `RSM_PORT_RST; // R3
      nxt.port_od = 1'b1; // R3
      nxt.clk_int = 1'b1; // R5
      nxt.wdt_en = 1'b1; // R6
    end
    else
    begin
      if (port_wr_i)
        nxt.port_latch = port_data_i;
      if (clk_ext_sel_i)
        nxt.clk_int = 1'b0;
      if (wdt_off_i)
        nxt.wdt_en = 1'b0;
    end
    // one pulse tells the core to restart from the reset vector
    nxt.start_pulse = (r.phase != rsm_pkg::RSM_RUN) && !in_rst; // R5

    // register read data, reserved bits read zero
    nxt.rdata = 8'h00;
    if (sfr_i.rd && sfr_i.addr == `RSM_SUPPLY_CTRL_ADDR)
    begin
      nxt.rdata[`RSM_MON_EN_BIT] = r.mon_en;
      nxt.rdata[`RSM_SUPPLY_STAT_BIT] = supply_s;
    end
    else if (sfr_i.rd && sfr_i.addr == `RSM_CAUSE_ADDR)
    begin
      nxt.rdata[`RSM_PIN_FLAG_BIT] = r.pin_flag;
      nxt.rdata[`RSM_POR_FLAG_BIT] = r.por_flag;
    end
  end

  // a hard reset behaves as a power-on
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      r <= '0;
      r.phase <= rsm_pkg::RSM_PWR;
      r.mon_en <= 1'b1;
      r.core_rst <= 1'b1;
      r.pin_drive <= 1'b1;
      r.port_latch <= `RSM_PORT_RST;
      r.port_od <= 1'b1;
      r.pullup_en <= 1'b1;
      r.clk_int <= 1'b1;
      r.wdt_en <= 1'b1;
    end
    else
      r <= nxt;
  end

  // ------------------------------------------------------------
  // watchdog clock divider
  // ------------------------------------------------------------
  rsm_div u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(r.wdt_en && !r.core_rst),
    .tick_o(wdt_tick_o)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sfr_rdata_o = r.rdata;
  assign rst_pin_o = 1'b0; // open drain: only ever pulls low
  assign rst_pin_oe_o = r.pin_drive;
  assign core_rst_o = r.core_rst;
  assign start_pulse_o = r.start_pulse;
  assign reset_vec_o = `RSM_PC_RST;
  assign port_latch_o = r.port_latch;
  assign port_od_o = r.port_od;
  assign pullup_en_o = r.pullup_en;
  assign clk_int_o = r.clk_int;
  assign wdt_en_o = r.wdt_en;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_core_halted: assert property (r.phase != rsm_pkg::RSM_RUN |-> r.core_rst && !r.mon_sel) // R1
    else $error("core not held in reset");
  a_port_ones: assert property (r.core_rst |-> r.port_latch == 8'hff && r.port_od && r.pullup_en) // R3
    else $error("port state wrong in reset");
  a_pin_low: assert property (r.phase inside {rsm_pkg::RSM_PWR, rsm_pkg::RSM_MON} |-> r.pin_drive) // R4
    else $error("reset pin not driven");
  a_start_clean: assert property (r.start_pulse |-> r.clk_int && r.wdt_en && !r.core_rst) // R5
    else $error("bad state at reset exit");
  a_wdt_period: assert property (wdt_tick_o && r.wdt_en && !r.core_rst ##1 (r.wdt_en && !r.core_rst)[*8]
                                 |-> !wdt_tick_o) // R6
    else $error("watchdog tick too early");
  a_power_hold: assert property (r.phase == rsm_pkg::RSM_PWR && !supply_s |=> r.phase == rsm_pkg::RSM_PWR) // R7
    else $error("left power-up hold early");
  a_por_delay: assert property (r.phase == rsm_pkg::RSM_DLY ##1 r.phase == rsm_pkg::RSM_RUN
                                |-> $past(r.dly_cnt) == POR_LAST_INT && r.por_flag) // R14
    else $error("release delay wrong");
  a_por_cleared: assert property (r.phase inside {rsm_pkg::RSM_MON, rsm_pkg::RSM_SYS, rsm_pkg::RSM_PIN}
                                  ##1 r.phase == rsm_pkg::RSM_RUN |-> !r.por_flag) // R8
    else $error("power-on flag not cleared");
  a_mon_kept: assert property (r.phase == rsm_pkg::RSM_RUN ##1 r.phase == rsm_pkg::RSM_SYS
                               |-> $stable(r.mon_en)) // R9
    else $error("monitor enable changed");
  a_soft_por: assert property (r.phase == rsm_pkg::RSM_RUN && !mon_trip && !pin_trip && cause_wr &&
                               sfr_i.wdata[`RSM_PIN_FLAG_BIT] |=> r.phase == rsm_pkg::RSM_PWR ##1 r.mon_en) // R10
    else $error("software power-on missing");
  a_mon_trip: assert property (r.phase == rsm_pkg::RSM_RUN && mon_trip |=> r.phase == rsm_pkg::RSM_MON &&
                               r.pin_drive) // R11
    else $error("monitor reset missing");
  a_sel_fault: assert property (r.phase == rsm_pkg::RSM_RUN && !pin_trip && cause_wr &&
                                sfr_i.wdata[1:0] == 2'h2 && !mon_stable |=> r.phase == rsm_pkg::RSM_SYS) // R12
    else $error("unready select not reset");
  a_mon_gate: assert property (r.phase == rsm_pkg::RSM_RUN && !r.mon_sel |=> r.phase != rsm_pkg::RSM_MON) // R13
    else $error("unselected monitor reset");

endmodule : rsm_top
`default_nettype wire

// ### bench/rsm_far.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// external reset circuit and monitored supply
// ------------------------------------------------------------
module rsm_far (
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic supply_good_i,
  input wire logic ext_low_i,
  output logic supply_ok_o,
  output logic pin_n_o
);
  // supply indication lags the rail by a cycle, like a real comparator
  always_ff @(posedge clk_i)
  begin
    supply_ok_o <= supply_good_i;
  end
  // pull-up on the pin; either party may pull it low
  assign pin_n_o = ~(oe_i | ext_low_i);
endmodule : rsm_far
`default_nettype wire

// ### bench/reset_source_and_supply_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsm_consts.svh"
module reset_source_and_supply_monitor_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply_good = 1'b0;
  logic ext_low = 1'b0;
  logic supply_ok;
  logic pin_n;
  rsm_pkg::rsm_sfr_req_type sfr_i = '0;
  logic port_wr_i = 1'b0;
  logic [7:0] port_data_i = 8'h00;
  logic clk_ext_sel_i = 1'b0;
  logic wdt_off_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic rst_pin_oe_o, core_rst_o, start_pulse_o, port_od_o, pullup_en_o, clk_int_o, wdt_en_o, wdt_tick_o;
  logic rst_pin_o;
  logic [15:0] reset_vec_o;
  logic [7:0] port_latch_o;
  logic [7:0] q;
  logic [7:0] d;
  int n_errors = 0;
  int compares = 0;
  int seed = 4375;
  int n;

  always #50 clk_i = ~clk_i;

  rsm_far far_u (.clk_i(clk_i), .oe_i(rst_pin_oe_o), .supply_good_i(supply_good), .ext_low_i(ext_low),
    .supply_ok_o(supply_ok), .pin_n_o(pin_n));

  // short settle count keeps the monitor scenarios quick
  rsm_top #(.MON_SETTLE_CYC(16'h0004)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok),
    .rst_pin_n_i(pin_n), .sfr_i(sfr_i), .port_wr_i(port_wr_i), .port_data_i(port_data_i),
    .clk_ext_sel_i(clk_ext_sel_i), .wdt_off_i(wdt_off_i), .sfr_rdata_o(sfr_rdata_o), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_o(rst_pin_oe_o), .core_rst_o(core_rst_o), .start_pulse_o(start_pulse_o),
    .reset_vec_o(reset_vec_o), .port_latch_o(port_latch_o), .port_od_o(port_od_o),
    .pullup_en_o(pullup_en_o), .clk_int_o(clk_int_o), .wdt_en_o(wdt_en_o), .wdt_tick_o(wdt_tick_o));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task summarize();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : tick

  // one register cycle; read data lands the cycle after the strobe
  task sfr(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [7:0] rq);
    @(posedge clk_i);
    sfr_i <= '{a, w, ~w, wd};
    @(posedge clk_i);
    sfr_i <= '0;
    #1 rq = sfr_rdata_o;
  endtask : sfr

  // bounded wait on the core reset level, counting cycles
  task wait_core(input logic v, output int c);
    c = 0;
    while (core_rst_o !== v)
    begin
      tick(1);
      c++;
      if (c > 5000)
      begin
        check(core_rst_o, v);
        summarize();
      end
    end
  endtask : wait_core

  function automatic logic [7:0] cause_exp(input logic por, input logic pin);
    return {6'h00, por, pin};
  endfunction : cause_exp

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    tick(1);
    check(core_rst_o, 1'b1);
    check(rst_pin_oe_o, 1'b1);
    check(rst_pin_o, 1'b0);
    check(port_latch_o, `RSM_PORT_RST);
    check({port_od_o, pullup_en_o}, 2'h3);
    check(clk_int_o, 1'b1);
    check({wdt_en_o, wdt_tick_o}, 2'h2);
    @(posedge clk_i) rst_n_i <= 1'b1;
    tick(20);
    check({core_rst_o, rst_pin_oe_o}, 2'h3);
    @(posedge clk_i) supply_good <= 1'b1;
    wait_core(1'b0, n);
    check(n >= 3000 && n <= 3008, 1'b1);
    check({start_pulse_o, rst_pin_oe_o}, 2'h2);
    check(reset_vec_o, `RSM_PC_RST);
    tick(1);
    check(start_pulse_o, 1'b0);
    sfr(`RSM_CAUSE_ADDR, 1'b0, 8'h00, q);
    check(q[1], 1'b1);
    sfr(`RSM_SUPPLY_CTRL_ADDR, 1'b0, 8'h00, q);
    check(q, 8'hc0);
    // watchdog tick spacing
    n = 0;
    while (wdt_tick_o !== 1'b1 && n < 40) begin tick(1); n++; end
    n = 0;
    tick(1);
    while (wdt_tick_o !== 1'b1 && n < 40) begin tick(1); n++; end
    check(n + 1, `RSM_WDT_DIV);
    // random port data and unmapped reads
    repeat (4)
    begin
      d = 8'($random(seed));
      @(posedge clk_i);
      port_wr_i <= 1'b1;
      port_data_i <= d;
      @(posedge clk_i) port_wr_i <= 1'b0;
      #1 check(port_latch_o, d);
      sfr({1'b0, d[6:0]}, 1'b0, 8'h00, q);
      check(q, 8'h00);
    end
    @(posedge clk_i);
    clk_ext_sel_i <= 1'b1;
    wdt_off_i <= 1'b1;
    @(posedge clk_i);
    clk_ext_sel_i <= 1'b0;
    wdt_off_i <= 1'b0;
    tick(2);
    check({clk_int_o, wdt_en_o}, 2'h0);
    // software forced power-on reset
    sfr(`RSM_CAUSE_ADDR, 1'b1, 8'h01, q);
    tick(1);
    check({core_rst_o, rst_pin_oe_o}, 2'h3);
    check(port_latch_o, `RSM_PORT_RST);
    check({clk_int_o, wdt_en_o}, 2'h3);
    wait_core(1'b0, n);
    check(n >= 2998 && n <= 3006, 1'b1);
    sfr(`RSM_CAUSE_ADDR, 1'b0, 8'h00, q);
    check(q[1], 1'b1);
    // selecting a disabled monitor resets the system, pin untouched
    sfr(`RSM_SUPPLY_CTRL_ADDR, 1'b1, 8'h00, q);
    sfr(`RSM_CAUSE_ADDR, 1'b1, 8'h02, q);
    wait_core(1'b1, n);
    check(rst_pin_oe_o, 1'b0);
    wait_core(1'b0, n);
    sfr(`RSM_CAUSE_ADDR, 1'b0, 8'h00, q);
    check(q[1], 1'b0);
    sfr(`RSM_SUPPLY_CTRL_ADDR, 1'b0, 8'h00, q);
    check(q, 8'h40);
    // enabled but not selected: supply dip gives no reset
    sfr(`RSM_SUPPLY_CTRL_ADDR, 1'b1, 8'h80, q);
    tick(10);
    @(posedge clk_i) supply_good <= 1'b0;
    tick(8);
    check(core_rst_o, 1'b0);
    sfr(`RSM_SUPPLY_CTRL_ADDR, 1'b0, 8'h00, q);
    check(q, 8'h80);
    @(posedge clk_i) supply_good <= 1'b1;
    tick(6);
    // settled and selected: a dip resets with the pin pulled low
    sfr(`RSM_CAUSE_ADDR, 1'b1, 8'h02, q);
    tick(3);
    check(core_rst_o, 1'b0);
    @(posedge clk_i) supply_good <= 1'b0;
    wait_core(1'b1, n);
    check(n <= 6, 1'b1);
    tick(1);
    check(rst_pin_oe_o, 1'b1);
    @(posedge clk_i) supply_good <= 1'b1;
    wait_core(1'b0, n);
    check(rst_pin_oe_o, 1'b0);
    sfr(`RSM_CAUSE_ADDR, 1'b0, 8'h00, q);
    check(q, cause_exp(1'b0, 1'b0));
    // external pin reset
    tick(4);
    @(posedge clk_i) ext_low <= 1'b1;
    wait_core(1'b1, n);
    tick(3);
    check(rst_pin_oe_o, 1'b0);
    @(posedge clk_i) ext_low <= 1'b0;
    wait_core(1'b0, n);
    sfr(`RSM_CAUSE_ADDR, 1'b0, 8'h00, q);
    check(q, cause_exp(1'b0, 1'b1));
    summarize();
  end
endmodule : reset_source_and_supply_monitor_tb
`default_nettype wire
